//--- design/pmlhc_ctrl.sv
// Power-mode and limp-home controller of a four-channel low-side switch.
// Assumes a serial slave on clk that reports frames and channel writes.
//
// Overview of operation
// - After power-on reset, registers go to defaults and the device sits idle.
// - While reset pin is low, all registers are held at defaults.
// - Reset pin low with limp-home low means sleep; sleep clears registers.
// - Idle mode keeps all channels off with no diagnosis active.
// - On mode drives enabled channels with diagnostic currents active.
// - Limp-home pin high forces limp-home mode regardless of other inputs.
// - Limp-home clears registers and routes each direct input to its channel.
// - Serial channel commands are ignored during limp-home.
// - Limp-home overrides reset pin and wakes device from sleep.
// - Every frame during limp-home is answered with the error flag set.
// - Leaving limp-home resets registers, then sleep or on mode.
// - First frame after limp-home is answered with the error flag set.
// - All channels off without diagnosis puts the device into idle once no limp-home error flag is pending.
`timescale 1ns/1ps
module pmlhc_ctrl
  import pmlhc_pkg::*;
#(
  parameter int unsigned NUM_CH = PMLHC_NUM_CH
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic rst_pin_n,
  input wire logic limp_home_input,
  input wire logic [NUM_CH-1:0] direct_input_pin,
  input wire pmlhc_cfg_wr_t cfg_wr,
  input wire logic frame_start,
  output logic transmission_error_flag,
  output logic spi_enable,
  output logic reg_reset,
  output logic [NUM_CH-1:0] channel_output,
  output logic [NUM_CH-1:0] diag_enable,
  output pmlhc_mode_t power_mode
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // Pins are asynchronous to clk; stage one feeds only stage two.
  logic [1:0] lhi_s1_r, lhi_s1_nxt;
  logic [1:0] lhi_s2_r, lhi_s2_nxt;
  logic [NUM_CH-1:0] din_s1_r, din_s1_nxt;
  logic [NUM_CH-1:0] din_s2_r, din_s2_nxt;

  always_comb begin
    lhi_s1_nxt = {rst_pin_n, limp_home_input};
    lhi_s2_nxt = lhi_s1_r;
    din_s1_nxt = direct_input_pin;
    din_s2_nxt = din_s1_r;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      // Reset pin stages start released, so power-on stays idle
      lhi_s1_r <= 2'h2;
      lhi_s2_r <= 2'h2;
      din_s1_r <= '0;
      din_s2_r <= '0;
    end else begin
      lhi_s1_r <= lhi_s1_nxt;
      lhi_s2_r <= lhi_s2_nxt;
      din_s1_r <= din_s1_nxt;
      din_s2_r <= din_s2_nxt;
    end
  end

  logic lhi_q;
  logic rst_q_n;
  assign lhi_q = lhi_s2_r[0];
  assign rst_q_n = lhi_s2_r[1];

  // ****************************************************************
  // Mode machine and channel registers
  // ****************************************************************
  pmlhc_mode_t mode_r, mode_nxt;
  logic [1:0] chm_r [NUM_CH];
  logic [1:0] chm_nxt [NUM_CH];
  logic ter_pend_r, ter_pend_nxt;
  logic ter_r, ter_nxt;
  logic [NUM_CH-1:0] out_r, out_nxt;
  logic [NUM_CH-1:0] diag_r, diag_nxt;
  logic clr;
  logic all_off;

  always_comb begin
    all_off = 1'b1;
    for (int i = 0; i < NUM_CH; i++) begin
      if (chm_r[i] != PMLHC_CH_OFF_NODIAG) begin
        all_off = 1'b0;
      end
    end
  end

  always_comb begin
    mode_nxt = mode_r;
    unique case (mode_r)
      PMLHC_SLEEP: begin
        if (rst_q_n) begin
          mode_nxt = PMLHC_IDLE;
        end
      end
      PMLHC_IDLE: begin
        if (!rst_q_n) begin
          mode_nxt = PMLHC_SLEEP;
        end else if (!all_off) begin
          mode_nxt = PMLHC_ON;
        end
      end
      PMLHC_ON: begin
        if (!rst_q_n) begin
          mode_nxt = PMLHC_SLEEP;
        end else if (all_off && !ter_pend_r) begin
          mode_nxt = PMLHC_IDLE;
        end
      end
      PMLHC_LIMP: begin
        if (!lhi_q) begin
          // Stay on with diagnosis until the pending error is reported
          mode_nxt = rst_q_n ? PMLHC_ON : PMLHC_SLEEP;
        end
      end
    endcase
    if (lhi_q) begin
      mode_nxt = PMLHC_LIMP;
    end
  end

  // Registers clear in sleep, in limp-home and on leaving limp-home
  assign clr = (mode_r == PMLHC_SLEEP) || (mode_r == PMLHC_LIMP) ||
               (mode_nxt == PMLHC_LIMP) || !rst_q_n;

  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      chm_nxt[i] = chm_r[i];
      if (clr) begin
        chm_nxt[i] = PMLHC_CH_RESET;
      end else if (cfg_wr.valid && (cfg_wr.ch_sel == 2'(i))) begin
        chm_nxt[i] = cfg_wr.mode;
      end
    end
  end

  always_comb begin
    ter_pend_nxt = ter_pend_r;
    ter_nxt = ter_r;
    if (frame_start && (mode_r != PMLHC_SLEEP)) begin
      ter_nxt = (mode_r == PMLHC_LIMP) || ter_pend_r;
      ter_pend_nxt = 1'b0;
    end
    // Leaving limp-home wins over a frame in the same cycle
    if ((mode_r == PMLHC_LIMP) && !lhi_q) begin
      ter_pend_nxt = 1'b1;
    end
    if (mode_r == PMLHC_SLEEP) begin
      ter_nxt = 1'b0;
    end
  end

  always_comb begin
    out_nxt = '0;
    diag_nxt = '0;
    unique case (mode_r)
      PMLHC_LIMP: begin
        out_nxt = din_s2_r;
      end
      PMLHC_ON: begin
        for (int i = 0; i < NUM_CH; i++) begin
          diag_nxt[i] = 1'b1;
          unique case (chm_r[i])
            PMLHC_CH_ON_DIAG: out_nxt[i] = 1'b1;
            PMLHC_CH_DIRECT: out_nxt[i] = din_s2_r[i];
            PMLHC_CH_OFF_DIAG: out_nxt[i] = 1'b0;
            PMLHC_CH_OFF_NODIAG: diag_nxt[i] = 1'b0;
          endcase
        end
        if (all_off) begin
          diag_nxt = {NUM_CH{1'b1}};
        end
      end
      PMLHC_SLEEP, PMLHC_IDLE: begin
        out_nxt = '0;
        diag_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_r <= PMLHC_IDLE;
      for (int i = 0; i < NUM_CH; i++) begin
        chm_r[i] <= PMLHC_CH_RESET;
      end
      ter_pend_r <= 1'b0;
      ter_r <= 1'b0;
      out_r <= '0;
      diag_r <= '0;
    end else begin
      mode_r <= mode_nxt;
      for (int i = 0; i < NUM_CH; i++) begin
        chm_r[i] <= chm_nxt[i];
      end
      ter_pend_r <= ter_pend_nxt;
      ter_r <= ter_nxt;
      out_r <= out_nxt;
      diag_r <= diag_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign transmission_error_flag = ter_r;
  assign spi_enable = (mode_r != PMLHC_SLEEP);
  assign reg_reset = clr;
  assign channel_output = out_r;
  assign diag_enable = diag_r;
  assign power_mode = mode_r;

endmodule : pmlhc_ctrl

//--- design/pmlhc_pkg.sv
// Package of the power-mode and limp-home controller.
// Assumes a single 100 MHz clock domain and no software-visible registers.
package pmlhc_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int unsigned PMLHC_NUM_CH = 4;
  localparam int unsigned PMLHC_SYNC_STAGES = 2;

  // ****************************************************************
  // Channel modes held in the serial registers
  // ****************************************************************
  typedef enum logic [1:0] {
    PMLHC_CH_OFF_NODIAG = 2'h0,
    PMLHC_CH_DIRECT = 2'h1,
    PMLHC_CH_ON_DIAG = 2'h2,
    PMLHC_CH_OFF_DIAG = 2'h3
  } pmlhc_chmode_t;

  localparam logic [1:0] PMLHC_CH_RESET = 2'h0;

  // ****************************************************************
  // Power modes
  // ****************************************************************
  typedef enum logic [1:0] {
    PMLHC_SLEEP = 2'h0,
    PMLHC_IDLE = 2'h1,
    PMLHC_ON = 2'h2,
    PMLHC_LIMP = 2'h3
  } pmlhc_mode_t;

  // Channel configuration write from the serial slave
  typedef struct packed {
    logic valid;
    logic [1:0] ch_sel;
    logic [1:0] mode;
  } pmlhc_cfg_wr_t;

endpackage : pmlhc_pkg

//--- sim/pmlhc_ctrl_bench.sv
// Bench of the power-mode controller.
// Assumes the host model owns every mode pin and serial event.
`timescale 1ns/1ps
module pmlhc_ctrl_bench;
  import pmlhc_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic rst_pin_n, limp_home_input, frame_start, transmission_error_flag;
  logic spi_enable, reg_reset;
  logic [3:0] direct_input_pin, channel_output, diag_enable;
  pmlhc_cfg_wr_t cfg_wr;
  pmlhc_mode_t power_mode;
  int n_fail = 0;
  int n_compared = 0;
  int cycles = 0;
  always #5 clk = ~clk;
  pmlhc_host pmlhc_host_i (.clk, .rst_pin_n, .limp_home_input,
    .direct_input_pin, .cfg_wr, .frame_start);
  pmlhc_ctrl pmlhc_ctrl_i (.clk, .reset_n, .rst_pin_n, .limp_home_input,
    .direct_input_pin, .cfg_wr, .frame_start, .transmission_error_flag,
    .spi_enable, .reg_reset, .channel_output, .diag_enable, .power_mode);
  task automatic chk(input string what, input logic [3:0] seen,
    input logic [3:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic finish_test();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finish_test
  // Pins need three edges; six leaves room for the registered outputs
  task automatic settle();
    repeat (6) @(posedge clk);
    #1;
  endtask : settle
  task automatic flag(input logic exp);
    pmlhc_host_i.frame();
    #1;
    chk("error flag", {3'h0, transmission_error_flag}, {3'h0, exp});
  endtask : flag
  task automatic t_modes();
    settle();
    chk("mode", 4'(power_mode), 4'(PMLHC_IDLE));
    pmlhc_host_i.wr(2'h0, PMLHC_CH_ON_DIAG);
    settle();
    chk("mode", 4'(power_mode), 4'(PMLHC_ON));
    chk("outputs", channel_output, 4'h1);
    chk("diag", diag_enable, 4'h1);
    pmlhc_host_i.wr(2'h0, PMLHC_CH_OFF_NODIAG);
    settle();
    chk("mode", 4'(power_mode), 4'(PMLHC_IDLE));
    chk("idle drive", channel_output | diag_enable, 4'h0);
  endtask : t_modes
  task automatic t_limp();
    pmlhc_host_i.pins(1'b1, 1'b1, 4'h5);
    settle();
    chk("mode", 4'(power_mode), 4'(PMLHC_LIMP));
    pmlhc_host_i.wr(2'h1, PMLHC_CH_ON_DIAG);
    settle();
    chk("outputs", channel_output, 4'h5);
    flag(1'b1);
    pmlhc_host_i.pins(1'b1, 1'b0, 4'h5);
    settle();
    chk("outputs", channel_output, 4'h0);
    chk("diag", diag_enable, 4'hf);
    flag(1'b1);
    flag(1'b0);
  endtask : t_limp
  task automatic t_sleep();
    pmlhc_host_i.pins(1'b0, 1'b0, 4'hf);
    settle();
    chk("mode", 4'(power_mode), 4'(PMLHC_SLEEP));
    chk("outputs", channel_output, 4'h0);
    chk("spi enable", {3'h0, spi_enable}, 4'h0);
    chk("reg reset", {3'h0, reg_reset}, 4'h1);
    pmlhc_host_i.pins(1'b0, 1'b1, 4'h3);
    settle();
    chk("outputs", channel_output, 4'h3);
    pmlhc_host_i.pins(1'b0, 1'b0, 4'h3);
    settle();
    chk("mode", 4'(power_mode), 4'(PMLHC_SLEEP));
    chk("outputs", channel_output, 4'h0);
  endtask : t_sleep
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_fail++;
      finish_test();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    t_modes();
    t_limp();
    t_sleep();
    finish_test();
  end
endmodule : pmlhc_ctrl_bench

//--- sim/pmlhc_ctrl_sva.sv
// Checker of the power-mode controller, bound to its top module.
// Assumes one clock domain and the three-edge pin latency.
`timescale 1ns/1ps
module pmlhc_ctrl_sva
  import pmlhc_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic rst_pin_n,
  input wire logic limp_home_input,
  input wire logic [3:0] direct_input_pin,
  input wire logic frame_start,
  input wire logic transmission_error_flag,
  input wire logic spi_enable,
  input wire logic reg_reset,
  input wire logic [3:0] channel_output,
  input wire logic [3:0] diag_enable,
  input pmlhc_mode_t power_mode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Error owed to the first frame once limp-home is left
  logic pend_r;
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n) pend_r <= 1'b0;
    else if (power_mode == PMLHC_LIMP) pend_r <= 1'b1;
    else if (frame_start || power_mode == PMLHC_SLEEP) pend_r <= 1'b0;
  sequence limp_s; power_mode == PMLHC_LIMP; endsequence
  sequence lhi_up_s; $rose(limp_home_input); endsequence
  sequence on_s; power_mode == PMLHC_ON; endsequence
  por_idle_a: assert property ($rose(reset_n) |-> power_mode == PMLHC_IDLE)
    else $error("mode not idle after power-on");
  rst_sleep_a: assert property ((!rst_pin_n && !limp_home_input)[*5]
    |-> power_mode == PMLHC_SLEEP && reg_reset && !spi_enable)
    else $error("reset pin low without sleep");
  sleep_out_a: assert property ((power_mode == PMLHC_SLEEP)[*2]
    |-> channel_output == 4'h0) else $error("channel on in sleep");
  idle_out_a: assert property ((power_mode == PMLHC_IDLE)[*2]
    |-> (channel_output | diag_enable) == 4'h0)
    else $error("activity in idle");
  limp_entry_a: assert property (lhi_up_s |-> ##[1:4] limp_s)
    else $error("limp-home not entered");
  wake_limp_a: assert property (lhi_up_s ##0 power_mode == PMLHC_SLEEP
    |-> ##[1:4] limp_s) else $error("no wake into limp-home");
  limp_clear_a: assert property (limp_home_input[*3] |-> reg_reset)
    else $error("registers not cleared in limp-home");
  limp_ter_a: assert property (frame_start && power_mode == PMLHC_LIMP
    |=> transmission_error_flag) else $error("no error flag");
  post_ter_a: assert property (frame_start && pend_r &&
    power_mode == PMLHC_ON |=> transmission_error_flag)
    else $error("no error flag after limp-home");
  limp_route_a: assert property (limp_s |=>
    channel_output == $past(direct_input_pin, 3))
    else $error("channel not following its direct input");
  limp_exit_a: assert property (limp_s ##1 on_s |=>
    channel_output == 4'h0 && diag_enable == 4'hf)
    else $error("channels not off with diagnosis after limp-home");
endmodule : pmlhc_ctrl_sva
bind pmlhc_ctrl pmlhc_ctrl_sva pmlhc_ctrl_sva_i (.clk, .reset_n, .rst_pin_n,
  .limp_home_input, .direct_input_pin, .frame_start,
  .transmission_error_flag, .spi_enable,
  .reg_reset, .channel_output, .diag_enable, .power_mode);

//--- sim/pmlhc_host.sv
// Host model: mode pins, direct inputs and serial events.
// Assumes the controller samples everything on the rising edge of clk.
`timescale 1ns/1ps
module pmlhc_host
  import pmlhc_pkg::*;
(
  input wire logic clk,
  output logic rst_pin_n,
  output logic limp_home_input,
  output logic [3:0] direct_input_pin,
  output pmlhc_cfg_wr_t cfg_wr,
  output logic frame_start
);
  initial begin
    rst_pin_n = 1'b1;
    limp_home_input = 1'b0;
    direct_input_pin = 4'h0;
    cfg_wr = '0;
    frame_start = 1'b0;
  end
  // Pins are levels held until the next call
  task automatic pins(input logic r, input logic l, input logic [3:0] d);
    @(posedge clk);
    rst_pin_n <= r;
    limp_home_input <= l;
    direct_input_pin <= d;
  endtask : pins
  task automatic wr(input logic [1:0] ch, input logic [1:0] m);
    @(posedge clk);
    cfg_wr <= '{1'b1, ch, m};
    @(posedge clk);
    cfg_wr <= '0;
  endtask : wr
  task automatic frame();
    @(posedge clk);
    frame_start <= 1'b1;
    @(posedge clk);
    frame_start <= 1'b0;
  endtask : frame
endmodule : pmlhc_host
